// ===== core/frc_ctrl.v
// Purpose: control and gate logic of the frequency ratio counter
// Assumes: gate clocks are slow against ref_clk (under half its rate)
// Notes: the pulse tally itself lives outside; this block drives its enable and clear
// Function
// - done flag is a level request; cleared by software or by writing start.
// - done flag takes any value written without start; writing one raises the request.
// - done reads zero while measuring and one after, until cleared.
// - active bit reads one while busy; its fall at interval end sets the done flag.
// - every write of one to active with a nonzero gate source restarts, discarding the partial tally.
// - fast clock select 0 picks the lc oscillator, 1 the divider.
// - with gate source zero both fast clock enables stay inactive.
// - control bits 4 and 3 read zero, writes ignored.
// - gate source codes pick off, gpio, osc, sys, crystal or sleep clock.
// - gate length is (2 + bit0) shifted left by bits 5..1.
// - interval field above 43 gives a one-cycle gate.
// - gate source zero stops at once; nonzero idles until a start.
// - after start sync, enable on next gate edge; stop at interval end.
// - interval end clears active, done set later; tally held.
`timescale 1ns/100ps
`include "frc_defines.vh"
module frc_ctrl #(
  parameter LEN_W = `FRC_LEN_W
) (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // special-function register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  // gate clock sources, asynchronous
  input wire gate_gpio_clk,
  input wire gate_osc_clk,
  input wire gate_sys_clk,
  input wire crystal_clock,
  input wire gate_sleep_clk,
  // fast clock gating and tally control
  output reg lc_oscillator_en,
  output reg divider_en,
  output reg tally_clear,
  // completion request
  output wire measure_irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SYNC = 2'h1;
  localparam ST_ARM = 2'h2;
  localparam ST_COUNT = 2'h3;

  reg measure_complete_flag_q;
  reg measure_active_bit_q;
  reg fast_clock_select_q;
  reg [2:0] gate_source_field_q;
  reg [5:0] gate_length_field_q;
  reg [1:0] state_q;
  reg [LEN_W-1:0] edge_cnt_q;
  reg start_req_q;
  reg end_req_q;
  reg gate_prev_q;
  reg gate_mux;
  reg [LEN_W-1:0] gate_len;
  wire gate_s;
  wire gate_gpio_s;
  wire gate_osc_s;
  wire gate_sys_s;
  wire crystal_clock_s;
  wire gate_sleep_s;
  wire start_s;
  wire end_s;
  wire gate_rise;
  wire wr_ctrl;
  wire wr_intv;
  wire start_wr;
  wire mode_off;

  assign wr_ctrl = sfr_wr && (sfr_addr == `FRC_CTRL_ADDR);
  assign wr_intv = sfr_wr && (sfr_addr == `FRC_INTV_ADDR);
  assign start_wr = wr_ctrl && sfr_wdata[`FRC_BUSY_BIT];
  assign mode_off = (gate_source_field_q == `FRC_MODE_OFF);
  assign measure_irq = measure_complete_flag_q;

  // reserved codes fall to zero, which never yields an edge
  always @* begin
    case (gate_source_field_q)
      `FRC_MODE_GPIO: gate_mux = gate_gpio_s;
      `FRC_MODE_OSC: gate_mux = gate_osc_s;
      `FRC_MODE_SYS: gate_mux = gate_sys_s;
      `FRC_MODE_XO: gate_mux = crystal_clock_s;
      `FRC_MODE_SLEEP: gate_mux = gate_sleep_s;
      default: gate_mux = 1'b0;
    endcase
  end

  always @* begin
    if (gate_length_field_q > `FRC_INTV_MAX) begin
      gate_len = {{(LEN_W-1){1'b0}}, 1'b1};
    end else begin
      gate_len = {{(LEN_W-2){1'b0}}, 1'b1, gate_length_field_q[0]}
        << gate_length_field_q[5:1];
    end
  end

  // each pin synced ahead of the mux; a stray edge on a source switch
  // lands while the start is still syncing, so it is ignored
  frc_sync2 u_gpio_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d_in(gate_gpio_clk),
    .d_out(gate_gpio_s)
  );
  frc_sync2 u_osc_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d_in(gate_osc_clk),
    .d_out(gate_osc_s)
  );
  frc_sync2 u_sys_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d_in(gate_sys_clk),
    .d_out(gate_sys_s)
  );
  frc_sync2 u_xtal_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d_in(crystal_clock),
    .d_out(crystal_clock_s)
  );
  frc_sync2 u_sleep_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d_in(gate_sleep_clk),
    .d_out(gate_sleep_s)
  );
  assign gate_s = gate_mux;
  frc_sync2 u_start_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d_in(start_req_q),
    .d_out(start_s)
  );
  frc_sync2 u_end_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d_in(end_req_q),
    .d_out(end_s)
  );

  assign gate_rise = gate_s && !gate_prev_q;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fast_clock_select_q <= 1'b0;
      gate_source_field_q <= `FRC_MODE_OFF;
      gate_length_field_q <= `FRC_INTV_RESET;
      measure_complete_flag_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        fast_clock_select_q <= sfr_wdata[`FRC_SEL_BIT];
        gate_source_field_q <= sfr_wdata[`FRC_MODE_MSB:0];
      end
      if (wr_intv) begin
        gate_length_field_q <= sfr_wdata[`FRC_INTV_MSB:0];
      end
      // hardware set wins over any clear in the same cycle
      if (end_s) begin
        measure_complete_flag_q <= 1'b1;
      end else if (start_wr) begin
        measure_complete_flag_q <= 1'b0;
      end else if (wr_ctrl) begin
        measure_complete_flag_q <= sfr_wdata[`FRC_DONE_BIT];
      end
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      measure_active_bit_q <= 1'b0;
      edge_cnt_q <= {LEN_W{1'b0}};
      start_req_q <= 1'b0;
      end_req_q <= 1'b0;
      gate_prev_q <= 1'b0;
      tally_clear <= 1'b0;
      lc_oscillator_en <= 1'b0;
      divider_en <= 1'b0;
    end else begin
      gate_prev_q <= gate_s;
      start_req_q <= 1'b0;
      end_req_q <= 1'b0;
      tally_clear <= 1'b0;
      if (wr_ctrl && (sfr_wdata[`FRC_MODE_MSB:0] == `FRC_MODE_OFF)) begin
        state_q <= ST_IDLE;
        measure_active_bit_q <= 1'b0;
        tally_clear <= 1'b1;
      end else if (start_wr) begin
        state_q <= ST_SYNC;
        measure_active_bit_q <= 1'b1;
        start_req_q <= 1'b1;
        tally_clear <= 1'b1;
      end else begin
        case (state_q)
          ST_SYNC: begin
            if (start_s) begin
              state_q <= ST_ARM;
            end
          end
          ST_ARM: begin
            if (gate_rise) begin
              state_q <= ST_COUNT;
              edge_cnt_q <= {LEN_W{1'b0}};
            end
          end
          ST_COUNT: begin
            if (gate_rise) begin
              edge_cnt_q <= edge_cnt_q + 1'b1;
              if (edge_cnt_q + 1'b1 == gate_len) begin
                state_q <= ST_IDLE;
                measure_active_bit_q <= 1'b0;
                end_req_q <= 1'b1;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
      lc_oscillator_en <= 1'b0;
      divider_en <= 1'b0;
      if (!mode_off && (state_q == ST_COUNT)) begin
        lc_oscillator_en <= !fast_clock_select_q;
        divider_en <= fast_clock_select_q;
      end
    end
  end

  // read data registered on the read strobe
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      if (sfr_addr == `FRC_CTRL_ADDR) begin
        sfr_rdata <= {measure_complete_flag_q, measure_active_bit_q,
          fast_clock_select_q, 2'h0, gate_source_field_q};
      end else if (sfr_addr == `FRC_INTV_ADDR) begin
        sfr_rdata <= {2'h0, gate_length_field_q};
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end
endmodule // frc_ctrl

// ===== core/frc_defines.vh
// Purpose: constants of the frequency ratio counter control block
// Assumes: included by bare name from the design files
// Notes: register offsets are byte addresses in special-function space
`ifndef FRC_DEFINES_VH
`define FRC_DEFINES_VH
`define FRC_CTRL_ADDR 8'h9B
`define FRC_INTV_ADDR 8'h9D
`define FRC_CTRL_RESET 8'h00
`define FRC_INTV_RESET 6'h00
`define FRC_DONE_BIT 7
`define FRC_BUSY_BIT 6
`define FRC_SEL_BIT 5
`define FRC_MODE_MSB 2
`define FRC_INTV_MSB 5
`define FRC_MODE_OFF 3'h0
`define FRC_MODE_GPIO 3'h1
`define FRC_MODE_OSC 3'h2
`define FRC_MODE_SYS 3'h3
`define FRC_MODE_XO 3'h4
`define FRC_MODE_SLEEP 3'h6
`define FRC_INTV_MAX 6'h2B
`define FRC_LEN_W 23
`endif

// ===== core/frc_sync2.v
// Purpose: two-flop synchroniser for one bit
// Assumes: first stage is read only by the second
// Notes: reset value is zero
`timescale 1ns/100ps
module frc_sync2 (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // data
  input wire d_in,
  output wire d_out
);
  reg s1_q;
  reg s2_q;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
    end
  end
  assign d_out = s2_q;
endmodule // frc_sync2

// ===== tb/frc_ctrl_bench.sv
// Purpose: self-checking bench of frc_ctrl
// Assumes: gate clocks are counter taps, far below ref_clk
// Notes: expected read values pass a queue to a monitor
`timescale 1ns/100ps
module frc_ctrl_bench;
  reg ref_clk = 1'b0;
  reg nrst = 1'b0;
  reg sfr_wr = 1'b0, sfr_rd = 1'b0, pend_q = 1'b0, gp_q = 1'b0, sel = 1'b0;
  reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, g_q = 8'h00;
  reg [7:0] exp_q [$];
  reg [2:0] mode = 3'h1;
  wire [7:0] sfr_rdata;
  wire lc_oscillator_en, divider_en, tally_clear, measure_irq;
  integer num_errors = 0, samples_checked = 0, cyc = 0, cnt = 0, n, m, f, k;
  integer seed = 32'h9FD0;
  wire gs = g_q[mode == 3'h6 ? 7 : mode + 2];
  frc_ctrl u_dut (.ref_clk(ref_clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .gate_gpio_clk(g_q[3]), .gate_osc_clk(g_q[4]), .gate_sys_clk(g_q[5]),
    .crystal_clock(g_q[6]), .gate_sleep_clk(g_q[7]),
    .lc_oscillator_en(lc_oscillator_en), .divider_en(divider_en),
    .tally_clear(tally_clear), .measure_irq(measure_irq));
  always #5 ref_clk = ~ref_clk;
  task automatic chk(input [7:0] g, input [7:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_lvl(input g, input e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %0t irq %b exp %b", $time, g, e);
    end
  endtask
  task automatic chk_cnt(input [7:0] g, input [7:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %0t edges %0d exp %0d", $time, g, e);
    end
  endtask
  task end_sim;
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
  endtask
  // start, restart mid-way, then count gate edges inside the enable window
  task meas(input [2:0] md, input s, input [5:0] fi);
    mode = md;
    sel = s;
    n = fi > 6'd43 ? 1 : (2 + fi[0]) << fi[5:1];
    wr(8'h9D, {2'h0, fi});
    wr(8'h9B, {2'h1, s, 2'h0, md});
    repeat (20) @(posedge ref_clk);
    wr(8'h9B, {2'h1, s, 2'h3, md});
    rd(8'h9B, {2'h1, s, 2'h0, md});
    cnt = 0;
    k = 0;
    // look off the launching edge so the flag is settled
    while (measure_irq !== 1'b1 && k < 20000) begin
      @(negedge ref_clk);
      k = k + 1;
    end
    if (k >= 20000) begin
      num_errors = num_errors + 1;
    end
    chk_cnt(cnt[7:0], n[7:0]);
    rd(8'h9B, {2'h2, s, 2'h0, md});
  endtask
  always @(posedge ref_clk) begin
    g_q <= g_q + 8'h01;
    pend_q <= sfr_rd;
    cyc = cyc + 1;
    if (cyc == 90000) begin
      num_errors = num_errors + 1;
      end_sim;
    end
  end
  // monitor: oldest note against each read result
  always @(negedge ref_clk) begin
    if (pend_q) chk(sfr_rdata, exp_q.pop_front());
    if ((sel ? divider_en : lc_oscillator_en) && gs && !gp_q) cnt = cnt + 1;
    gp_q = gs;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(8'h9B, 8'h00);
    rd(8'h9D, 8'h00);
    wr(8'h9B, 8'h99);
    rd(8'h9B, 8'h81);
    chk_lvl(measure_irq, 1'b1);
    wr(8'h9D, 8'hFF);
    rd(8'h9D, 8'h3F);
    rd(8'h9C, 8'h00);
    meas(3'h1, 1'b0, 6'h2C);
    for (m = 0; m < 5; m = m + 1) begin
      f = $random(seed);
      meas(m == 4 ? 3'h6 : 3'(m + 1), m[0], f[2:0]);
    end
    wr(8'h9D, 8'h0A);
    wr(8'h9B, 8'h41);
    repeat (60) @(posedge ref_clk);
    wr(8'h9B, 8'h00);
    repeat (400) @(posedge ref_clk);
    chk_lvl(measure_irq, 1'b0);
    rd(8'h9B, 8'h00);
    // let the monitor take the last read before closing
    repeat (2) @(posedge ref_clk);
    end_sim;
  end
endmodule // frc_ctrl_bench

// ===== tb/frc_ctrl_checker.sv
// Purpose: port checks of frc_ctrl
// Assumes: bench strobes last one cycle
// Notes: bound by name at the foot
`timescale 1ns/100ps
module frc_ctrl_checker (
  // clock, reset
  input wire ref_clk,
  input wire nrst,
  // register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  // outputs
  input wire lc_oscillator_en,
  input wire divider_en,
  input wire tally_clear,
  input wire measure_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire wc = sfr_wr && sfr_addr == 8'h9B;
  wire en = lc_oscillator_en || divider_en;
  a_ctrl_rsv: assert property (sfr_rd && sfr_addr == 8'h9B |=> sfr_rdata[4:3] == 2'h0)
    else $error("ctrl bits 4:3 set");
  a_intv_rsv: assert property (sfr_rd && sfr_addr == 8'h9D |=> sfr_rdata[7:6] == 2'h0)
    else $error("interval bits 7:6 set");
  a_unmapped_zero: assert property (sfr_rd && sfr_addr != 8'h9B && sfr_addr != 8'h9D
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_fast_onehot: assert property (!(lc_oscillator_en && divider_en))
    else $error("both fast enables high");
  a_off_quiet: assert property (wc && sfr_wdata[2:0] == 3'h0 |=> ##1 !en [*4])
    else $error("enable while disabled");
  a_start_clear: assert property (wc && sfr_wdata[6] && sfr_wdata[2:0] != 3'h0
    |=> tally_clear) else $error("no tally clear on start");
  a_done_set: assert property (wc && sfr_wdata[7] && !sfr_wdata[6] |=> measure_irq)
    else $error("written done not raised");
  a_done_after: assert property ($fell(en) && !$past(sfr_wr) && !$past(sfr_wr, 2)
    |-> ##[1:5] measure_irq) else $error("no done after gate end");
endmodule // frc_ctrl_checker
bind frc_ctrl frc_ctrl_checker u_chk (.*);
